// File: core/msd_inrush_timer.v
// inrush mask timer: opens a mask window of a given length on a start pulse.
// assumes start_i is a one-cycle pulse and len_i is stable while counting.
`timescale 1ns/100ps

module msd_inrush_timer (
	input  wire        clk_sys_i,
	input  wire        rst_i,
	input  wire        start_i,
	input  wire        stop_i,
	input  wire [31:0] len_i,
	output reg         mask_o,
	output reg         done_o
);

	reg [31:0] cnt_q;

	// ----------------------------------------------------------------
	// window counter
	// ----------------------------------------------------------------
	// a zero length never opens the window, so no masking at all
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			cnt_q  <= 32'h0000_0000;
			mask_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (stop_i) begin
				cnt_q  <= 32'h0000_0000;
				mask_o <= 1'b0;
			end else if (start_i) begin
				cnt_q  <= len_i;
				mask_o <= (len_i != 32'h0000_0000);
			end else if (mask_o) begin
				if (cnt_q == 32'h0000_0001) begin
					mask_o <= 1'b0;
					done_o <= 1'b1; // window end event
				end
				cnt_q <= cnt_q - 32'h0000_0001;
			end
		end
	end

endmodule // msd_inrush_timer

// File: core/msd_stall_top.v
// motor stall detector: digital model of the hardware stall path of an
// h-bridge brushed dc motor driver, with an ahb-lite register slave.
// assumes sense and reference arrive as digitised levels synchronous to
// clk_sys_i, pin straps are static codes, and one bus master.
//
// Functional notes
// - stall is declared by comparing sense level against reference level
// - the comparison is ignored during the inrush window after startup
// - inrush window length comes from the timer capacitor setting
// - on a stall the active-low stall flag is pulled low
// - flag grounded with timer pin floating disables stall detection
// - detection disabled, mode select z: regulate whenever sense >= reference
// - flag grounded, timer grounded: about 6.7 s window, timer sources 10 ua
// - response select 0 with capacitor: stall disables and latches bridge off
// - response select 1 or z: stall only pulls flag, bridge stays on
// - floating timer with flag pulled up gives a zero inrush window
// - timer pin held above 1 v: zero window, discharge path left on
// - regulation mode select decides regulation during inrush and stall
// - reference sets the trip level for both detection and regulation
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/100ps
`include "msd_consts.vh"

module msd_stall_top #(
	parameter [31:0] GND_INRUSH_CYC = `MSD_GND_INRUSH_CYC,
	parameter [31:0] SLEEP_CYC      = `MSD_SLEEP_CYC
) (
	input  wire        clk_sys_i,
	input  wire        rst_i,
	// ahb-lite slave
	input  wire        hsel_i,
	input  wire [7:0]  haddr_i,
	input  wire [1:0]  htrans_i,
	input  wire        hwrite_i,
	input  wire [2:0]  hsize_i,
	input  wire [31:0] hwdata_i,
	input  wire        hready_i,
	output reg  [31:0] hrdata_o,
	output reg         hreadyout_o,
	output reg         hresp_o,
	// motor side
	input  wire        in1_i,
	input  wire        in2_i,
	input  wire [11:0] sense_level_i,
	input  wire [11:0] ref_level_i,
	input  wire        flag_grounded_i,
	input  wire [1:0]  inrush_timer_pin_i,
	input  wire [1:0]  stall_response_select_i,
	input  wire [1:0]  regulation_mode_select_i,
	output reg         stall_flag_n_o,
	output reg         stall_flag_oe_o,
	output reg         bridge_outputs_en_o,
	output reg         regulate_o,
	output reg         timer_source_o,
	output reg         timer_discharge_o,
	output reg         irq_o
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg  [31:0] ctrl_q;
	reg  [31:0] inrush_len_q;
	reg  [`MSD_EV_W-1:0] irq_stat_q;
	reg  [`MSD_EV_W-1:0] irq_mask_q;
	reg         wr_pend_q;
	reg  [7:0]  wr_addr_q;
	reg         drive_q;
	reg         asleep_q;
	reg  [31:0] idle_cnt_q;
	reg         latched_q;
	reg         stall_q;

	wire        drive = in1_i | in2_i;
	wire        start = drive & ~drive_q;
	wire        mask_win;
	wire        in_win;
	wire        win_end;
	wire        cmp;
	wire        det_en;
	wire        latch_mode;
	wire        stall_now;
	wire        reg_now;
	reg  [31:0] win_len;
	reg  [31:0] rd_mux;
	wire [`MSD_EV_W-1:0] ev_set;
	wire        addr_ph = hsel_i & htrans_i[1] & hready_i;

	// ----------------------------------------------------------------
	// comparator and configuration decode
	// ----------------------------------------------------------------
	// sense vs reference
	// one trip level serves detection and regulation alike
	assign cmp = (sense_level_i >= ref_level_i);

	// grounded flag with floating timer turns detection off
	assign det_en = ctrl_q[`MSD_CTRL_DET_EN] &
		~(flag_grounded_i & (inrush_timer_pin_i == `MSD_TMR_FLOAT));

	// latching needs response select low and a real capacitor
	// any other select code gives indication only
	assign latch_mode = (stall_response_select_i == `MSD_TRI_LOW) &
		(inrush_timer_pin_i == `MSD_TMR_CAP);

	// window length from the timer pin strap
	always @* begin
		case (inrush_timer_pin_i)
			// capacitor value is modelled by a programmed cycle count
			`MSD_TMR_CAP:   win_len = inrush_len_q;
			// grounded timer pin gives the long default window
			`MSD_TMR_GND:   win_len = GND_INRUSH_CYC;
			`MSD_TMR_FLOAT: win_len = 32'h0000_0000;
			// pin held high also means no window
			`MSD_TMR_HIGH:  win_len = 32'h0000_0000;
			default:        win_len = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// inrush window
	// ----------------------------------------------------------------
	// window restarts on each startup from an idle bridge
	msd_inrush_timer u_timer (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.start_i   (start),
		.stop_i    (~drive),
		.len_i     (win_len),
		.mask_o    (mask_win),
		.done_o    (win_end)
	);

	// start cycle masked too: the timer raises its window one edge late
	assign in_win = mask_win | (start & (win_len != 32'h0000_0000));

	// comparator result only counts outside the window
	assign stall_now = det_en & drive & ~in_win & cmp;

	// z regulates always, high during inrush and stall, low never
	assign reg_now = drive & cmp &
		((regulation_mode_select_i == `MSD_TRI_Z) |
		 ((regulation_mode_select_i == `MSD_TRI_HIGH) & (in_win | stall_now)));

	// ----------------------------------------------------------------
	// sleep tracking and stall latch
	// ----------------------------------------------------------------
	// both inputs low long enough puts the bridge to sleep
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			drive_q    <= 1'b0;
			asleep_q   <= 1'b0;
			idle_cnt_q <= 32'h0000_0000;
		end else begin
			drive_q <= drive;
			if (drive) begin
				idle_cnt_q <= 32'h0000_0000;
				asleep_q   <= 1'b0;
			end else if (idle_cnt_q >= SLEEP_CYC - 32'h0000_0001) begin
				asleep_q <= 1'b1;
			end else begin
				idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
			end
		end
	end

	// stall state and latched disable
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			stall_q   <= 1'b0;
			latched_q <= 1'b0;
		end else begin
			// indication follows the comparator while not latched
			stall_q <= stall_now | latched_q;
			// sleep entry clears the latch so the wake starts clean
			if (asleep_q) begin
				latched_q <= 1'b0;
				stall_q   <= 1'b0;
			// latch holds the bridge off once a stall is seen
			end else if (stall_now & latch_mode) begin
				latched_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// pin outputs
	// ----------------------------------------------------------------
	// open-drain flag: the level is always low, the enable pulls the pin
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			stall_flag_n_o      <= 1'b0;
			stall_flag_oe_o     <= 1'b0;
			bridge_outputs_en_o <= 1'b0;
			regulate_o          <= 1'b0;
			timer_source_o      <= 1'b0;
			timer_discharge_o   <= 1'b0;
		end else begin
			stall_flag_n_o      <= 1'b0;
			// pull the flag low while stalled
			stall_flag_oe_o     <= stall_now | (latched_q & ~asleep_q);
			// latched stall disables the bridge; sleep also idles it
			bridge_outputs_en_o <= drive & ~asleep_q & ~latched_q &
				~(stall_now & latch_mode);
			regulate_o          <= reg_now;
			// grounded flag and timer: source current continuously
			timer_source_o      <= flag_grounded_i &
				(inrush_timer_pin_i == `MSD_TMR_GND);
			// discharge path stays on while the pin is held high
			timer_discharge_o   <= (inrush_timer_pin_i == `MSD_TMR_HIGH) |
				((inrush_timer_pin_i == `MSD_TMR_CAP) & ~mask_win);
		end
	end

	// ----------------------------------------------------------------
	// interrupt events
	// ----------------------------------------------------------------
	// events are edges so a long stall raises its bit only once
	assign ev_set = {win_end,
		stall_now & latch_mode & ~latched_q & ~asleep_q,
		stall_now & ~stall_q};

	// ----------------------------------------------------------------
	// ahb-lite slave
	// ----------------------------------------------------------------
	// read mux sampled in the address phase so data stands registered
	always @* begin
		case (haddr_i)
			`MSD_ADDR_CTRL:     rd_mux = ctrl_q;
			`MSD_ADDR_INRUSH:   rd_mux = inrush_len_q;
			`MSD_ADDR_STATE:    rd_mux = {26'h000_0000, reg_now, asleep_q,
				latched_q, stall_q, cmp, mask_win};
			`MSD_ADDR_IRQ_STAT: rd_mux = {29'h0000_0000, irq_stat_q};
			`MSD_ADDR_IRQ_MASK: rd_mux = {29'h0000_0000, irq_mask_q};
			default:            rd_mux = 32'h0000_0000;
		endcase
	end

	// zero wait state; unmapped addresses read zero and ignore writes
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			hrdata_o     <= 32'h0000_0000;
			hreadyout_o  <= 1'b1;
			hresp_o      <= 1'b0;
			wr_pend_q    <= 1'b0;
			wr_addr_q    <= 8'h00;
			ctrl_q       <= `MSD_CTRL_RST;
			inrush_len_q <= `MSD_INRUSH_RST;
			irq_mask_q   <= {`MSD_EV_W{1'b0}};
		end else begin
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
			wr_pend_q   <= addr_ph & hwrite_i;
			wr_addr_q   <= haddr_i;
			if (addr_ph & ~hwrite_i) begin
				hrdata_o <= rd_mux;
			end
			if (wr_pend_q) begin
				case (wr_addr_q)
					`MSD_ADDR_CTRL:     ctrl_q <= {31'h0000_0000,
						hwdata_i[`MSD_CTRL_DET_EN]};
					`MSD_ADDR_INRUSH:   inrush_len_q <= hwdata_i;
					`MSD_ADDR_IRQ_MASK: irq_mask_q <= hwdata_i[`MSD_EV_W-1:0];
					default:            ctrl_q <= ctrl_q;
				endcase
			end
		end
	end

	// sticky status, write one to clear; a new event wins over the clear
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			irq_stat_q <= {`MSD_EV_W{1'b0}};
			irq_o      <= 1'b0;
		end else begin
			if (wr_pend_q & (wr_addr_q == `MSD_ADDR_IRQ_STAT)) begin
				irq_stat_q <= (irq_stat_q & ~hwdata_i[`MSD_EV_W-1:0]) | ev_set;
			end else begin
				irq_stat_q <= irq_stat_q | ev_set;
			end
			irq_o <= |(irq_stat_q & irq_mask_q);
		end
	end

endmodule // msd_stall_top

// File: inc/msd_consts.vh
// constants for the motor stall detector: register map, field positions,
// reset values, pin-strap codes and timing figures.
// assumes a 200 MHz system clock and a 32-bit AHB-Lite register bus.
`ifndef MSD_CONSTS_VH
`define MSD_CONSTS_VH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define MSD_CLK_KHZ          200000
`define MSD_T_GND_INRUSH_MS  6700
`define MSD_GND_INRUSH_CYC   (`MSD_T_GND_INRUSH_MS * `MSD_CLK_KHZ)
`define MSD_T_SLEEP_US       1
`define MSD_SLEEP_CYC        (`MSD_T_SLEEP_US * (`MSD_CLK_KHZ / 1000))

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define MSD_ADDR_CTRL        8'h00
`define MSD_ADDR_INRUSH      8'h04
`define MSD_ADDR_STATE       8'h08
`define MSD_ADDR_IRQ_STAT    8'h0c
`define MSD_ADDR_IRQ_MASK    8'h10

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define MSD_CTRL_DET_EN      0
`define MSD_CTRL_RST         32'h0000_0001
`define MSD_INRUSH_RST       32'h0000_0000
`define MSD_ST_MASK          0
`define MSD_ST_CMP           1
`define MSD_ST_STALL         2
`define MSD_ST_LATCH         3
`define MSD_ST_ASLEEP        4
`define MSD_ST_REG           5
`define MSD_EV_STALL         0
`define MSD_EV_LATCH         1
`define MSD_EV_WIN_END       2
`define MSD_EV_W             3

// ----------------------------------------------------------------
// pin-strap codes
// ----------------------------------------------------------------
`define MSD_TRI_LOW          2'h0
`define MSD_TRI_HIGH         2'h1
`define MSD_TRI_Z            2'h2
`define MSD_TMR_FLOAT        2'h0
`define MSD_TMR_GND          2'h1
`define MSD_TMR_CAP          2'h2
`define MSD_TMR_HIGH         2'h3

`endif

// File: testbench/msd_mcu_model.sv
// controller model: drives the bridge inputs and reads the stall flag.
// assumes the flag line has a pull-up unless the strap grounds it.
`timescale 1ns/100ps

module msd_mcu_model (
	input  wire       clk_sys_i,
	input  wire [1:0] run_i,
	input  wire       flag_oe_i,
	input  wire       flag_gnd_i,
	output reg        in1_o,
	output reg        in2_o,
	output wire       stall_seen_o
);
	// open drain: pulled low by the device or by the strap, else high
	assign stall_seen_o = flag_oe_i | flag_gnd_i;
	initial in1_o = 1'b0;
	initial in2_o = 1'b0;
	// full duty, the optional ramp is not used
	always @(posedge clk_sys_i) begin
		in1_o <= run_i[0];
		in2_o <= run_i[1];
	end
endmodule // msd_mcu_model

// File: testbench/msd_stall_chk_sva.sv
// checker for the stall path of msd_stall_top, seen at its pins only.
// assumes straps change only while both bridge inputs are low.
`timescale 1ns/100ps
`include "msd_consts.vh"

module msd_stall_chk #(
	parameter [31:0] GND_INRUSH_CYC = 32'd50,
	parameter [31:0] SLEEP_CYC      = 32'd8
) (
	input wire        clk_sys_i,
	input wire        rst_i,
	input wire        in1_i,
	input wire        in2_i,
	input wire [11:0] sense_level_i,
	input wire [11:0] ref_level_i,
	input wire        flag_grounded_i,
	input wire [1:0]  inrush_timer_pin_i,
	input wire [1:0]  stall_response_select_i,
	input wire [1:0]  regulation_mode_select_i,
	input wire        stall_flag_n_o,
	input wire        stall_flag_oe_o,
	input wire        bridge_outputs_en_o,
	input wire        regulate_o,
	input wire        timer_source_o
);
	wire        drv_w = in1_i | in2_i;
	wire        lat_w = inrush_timer_pin_i == `MSD_TMR_CAP && stall_response_select_i == 2'h0;
	reg         drv_q;
	reg  [31:0] since_q;
	// cycles since drive start; saturates so a long run never wraps back
	always @(posedge clk_sys_i) begin
		drv_q <= drv_w & ~rst_i;
		if (rst_i || (drv_w && !drv_q))
			since_q <= 32'h0;
		else if (since_q != 32'hffff_ffff)
			since_q <= since_q + 32'h1;
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	sequence s_drv3; drv_w [*3]; endsequence
	sequence s_trip2; (drv_w && sense_level_i >= ref_level_i) [*2]; endsequence
	property p_flag; stall_flag_oe_o |-> !stall_flag_n_o; endproperty
	a_flag: assert property (p_flag) else $error("flag level high");
	property p_win; inrush_timer_pin_i == `MSD_TMR_GND && since_q <= GND_INRUSH_CYC
		|-> !$rose(stall_flag_oe_o); endproperty
	a_win: assert property (p_win) else $error("flag inside window");
	property p_dis; (flag_grounded_i && inrush_timer_pin_i == 2'h0) [*2] |-> !stall_flag_oe_o;
	endproperty
	a_dis: assert property (p_dis) else $error("flag while disabled");
	property p_regz; regulation_mode_select_i == `MSD_TRI_Z ##0 s_trip2 |=> regulate_o; endproperty
	a_regz: assert property (p_regz) else $error("no regulation at trip");
	property p_src; (flag_grounded_i && inrush_timer_pin_i == `MSD_TMR_GND) [*2] |-> timer_source_o;
	endproperty
	a_src: assert property (p_src) else $error("timer not sourcing");
	property p_latch; lat_w && $rose(stall_flag_oe_o) |-> !bridge_outputs_en_o; endproperty
	a_latch: assert property (p_latch) else $error("bridge on at latch");
	property p_ind; s_drv3 ##0 (!lat_w && stall_flag_oe_o) |-> bridge_outputs_en_o; endproperty
	a_ind: assert property (p_ind) else $error("bridge off on indication");
	property p_low; (regulation_mode_select_i == 2'h0) [*2] |-> !regulate_o; endproperty
	a_low: assert property (p_low) else $error("regulating in low mode");
	property p_hold; lat_w && stall_flag_oe_o && drv_w && !bridge_outputs_en_o
		|=> !bridge_outputs_en_o; endproperty
	a_hold: assert property (p_hold) else $error("latch released early");
endmodule // msd_stall_chk

bind msd_stall_top msd_stall_chk #(
	.GND_INRUSH_CYC(GND_INRUSH_CYC),
	.SLEEP_CYC     (SLEEP_CYC)
) u_chk (
	.clk_sys_i, .rst_i, .in1_i, .in2_i, .sense_level_i, .ref_level_i, .flag_grounded_i,
	.inrush_timer_pin_i, .stall_response_select_i, .regulation_mode_select_i,
	.stall_flag_n_o, .stall_flag_oe_o, .bridge_outputs_en_o, .regulate_o, .timer_source_o
);

// File: testbench/tb.sv
// testbench for msd_stall_top with a controller model on the motor side.
// assumes the bus answers with zero wait states but waits for it anyway.
`timescale 1ns/100ps
`include "msd_consts.vh"

module tb;
	localparam [31:0] WIN = 32'd50;
	reg         clk_sys_i, rst_i, hsel_i, hwrite_i, flag_grounded_i;
	reg  [1:0]  run, htrans_i, inrush_timer_pin_i, stall_response_select_i;
	reg  [1:0]  regulation_mode_select_i;
	reg  [2:0]  hsize_i;
	reg  [7:0]  haddr_i;
	reg  [11:0] sense_level_i, ref_level_i;
	reg  [31:0] hwdata_i, rd;
	wire [31:0] hrdata_o;
	wire        hreadyout_o, hresp_o, in1_i, in2_i, stall_flag_n_o, stall_flag_oe_o, seen;
	wire        bridge_outputs_en_o, regulate_o, timer_source_o, timer_discharge_o, irq_o;
	integer     failures, num_checks, n, i;

	msd_stall_top #(.GND_INRUSH_CYC(WIN), .SLEEP_CYC(32'd8)) dut (
		.clk_sys_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
		.hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .in1_i, .in2_i,
		.sense_level_i, .ref_level_i, .flag_grounded_i, .inrush_timer_pin_i,
		.stall_response_select_i, .regulation_mode_select_i, .stall_flag_n_o,
		.stall_flag_oe_o, .bridge_outputs_en_o, .regulate_o, .timer_source_o,
		.timer_discharge_o, .irq_o);
	msd_mcu_model u_mcu (.clk_sys_i, .run_i(run), .flag_oe_i(stall_flag_oe_o),
		.flag_gnd_i(flag_grounded_i), .in1_o(in1_i), .in2_o(in2_i), .stall_seen_o(seen));

	task stop_test;
		begin
			$display("checks %0d failures %0d", num_checks, failures);
			if (failures == 0 && num_checks > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] exp, input [31:0] got);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
			end
		end
	endtask
	task cyc(input integer c);
		repeat (c) @(posedge clk_sys_i);
	endtask
	// bounded wait for hready at a rising edge; running out ends the run
	task wait_rdy;
		begin
			n = 0;
			@(posedge clk_sys_i);
			while (hreadyout_o !== 1'b1) begin
				n = n + 1;
				if (n > 20) begin
					failures = failures + 1;
					stop_test;
				end
				@(posedge clk_sys_i);
			end
		end
	endtask
	task bus(input w, input [7:0] a, input [31:0] d);
		begin
			hsel_i <= 1'b1;
			haddr_i <= a;
			hwrite_i <= w;
			htrans_i <= 2'h2;
			wait_rdy;
			htrans_i <= 2'h0;
			hsel_i <= 1'b0;
			hwdata_i <= d;
			wait_rdy;
			rd = hrdata_o;
		end
	endtask
	task wait_flag;
		begin
			n = 0;
			while (seen !== 1'b1) begin
				@(posedge clk_sys_i);
				n = n + 1;
				if (n > 40) begin
					failures = failures + 1;
					stop_test;
				end
			end
		end
	endtask
	// selects set low, high or released, only while the motor is idle
	task cfg(input f, input [1:0] t, input [1:0] s, input [1:0] m);
		begin
			flag_grounded_i <= f;
			inrush_timer_pin_i <= t;
			stall_response_select_i <= s;
			regulation_mode_select_i <= m;
		end
	endtask
	// both inputs low long enough to reach sleep
	task halt;
		begin
			run <= 2'b00;
			cyc(12);
		end
	endtask

	task t_dis;
		begin
			bus(0, `MSD_ADDR_CTRL, 0);
			chk("ctrl", `MSD_CTRL_RST, rd);
			bus(1, 8'h40, 32'hffff_ffff);
			bus(0, 8'h40, 0);
			chk("unmapped", 0, rd);
			chk("hresp", 0, hresp_o);
			cfg(1'b1, 2'h0, 2'h1, `MSD_TRI_Z);
			sense_level_i <= 12'h400;
			run <= 2'b01;
			cyc(20);
			chk("dis_flag", 0, stall_flag_oe_o);
			chk("reg_eq", 1, regulate_o);
			sense_level_i <= 12'h3ff;
			cyc(3);
			chk("reg_below", 0, regulate_o);
			halt;
			$display("test disabled done");
		end
	endtask
	task t_ind;
		begin
			for (i = 0; i < 2; i = i + 1) begin
				bus(1, `MSD_ADDR_INRUSH, 32'd10 + 4 * i);
				cfg(1'b0, `MSD_TMR_CAP, i ? `MSD_TRI_Z : 2'h1, 2'h1);
				sense_level_i <= 12'h800;
				run <= 2'b01;
				cyc(6);
				chk("reg_win", 1, regulate_o);
				chk("flag_win", 0, seen);
				wait_flag;
				chk("win_len", 1, n >= 8 + 4 * i && n <= 9 + 4 * i);
				chk("bridge_on", 1, bridge_outputs_en_o);
				sense_level_i <= 12'h100;
				cyc(4);
				chk("flag_follow", 0, seen);
				halt;
			end
			$display("test indication done");
		end
	endtask
	task t_latch;
		begin
			bus(1, `MSD_ADDR_IRQ_STAT, 32'h7);
			bus(1, `MSD_ADDR_IRQ_MASK, 32'h0);
			bus(1, `MSD_ADDR_INRUSH, 32'd4);
			cfg(1'b0, `MSD_TMR_CAP, 2'h0, 2'h0);
			sense_level_i <= 12'h800;
			run <= 2'b01;
			wait_flag;
			chk("latch_off", 0, bridge_outputs_en_o);
			sense_level_i <= 12'h100;
			cyc(4);
			chk("latch_flag", 1, seen);
			chk("flag_lvl", 0, stall_flag_n_o);
			bus(0, `MSD_ADDR_STATE, 0);
			chk("state", (32'h1 << `MSD_ST_LATCH) | (32'h1 << `MSD_ST_STALL), rd);
			bus(0, `MSD_ADDR_IRQ_STAT, 0);
			chk("irq_stat", 32'h7, rd);
			chk("irq_masked", 0, irq_o);
			bus(1, `MSD_ADDR_IRQ_MASK, 32'h2);
			cyc(2);
			chk("irq_on", 1, irq_o);
			bus(1, `MSD_ADDR_IRQ_STAT, 32'h2);
			cyc(2);
			chk("irq_clr", 0, irq_o);
			halt;
			run <= 2'b01;
			cyc(5);
			chk("wake_on", 1, bridge_outputs_en_o);
			chk("wake_flag", 0, seen);
			halt;
			$display("test latch done");
		end
	endtask
	task t_pins;
		begin
			cfg(1'b0, 2'h0, 2'h1, 2'h0);
			sense_level_i <= 12'h800;
			run <= 2'b10;
			wait_flag;
			chk("zero_win", 1, n <= 6);
			halt;
			cfg(1'b0, `MSD_TMR_HIGH, 2'h1, 2'h0);
			cyc(3);
			chk("discharge", 1, timer_discharge_o);
			cfg(1'b1, `MSD_TMR_GND, 2'h1, `MSD_TRI_Z);
			run <= 2'b01;
			cyc(WIN - 5);
			chk("gnd_src", 1, timer_source_o);
			chk("gnd_win", 0, stall_flag_oe_o);
			chk("gnd_reg", 1, regulate_o);
			halt;
			$display("test pins done");
		end
	endtask

	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	// reset six cycles, then the scenarios in turn
	initial begin
		{rst_i, hsel_i, hwrite_i, run, htrans_i, haddr_i, hwdata_i} = {1'b1, 46'h0};
		hsize_i = 3'h2;
		ref_level_i = 12'h400;
		sense_level_i = 12'h0;
		cfg(1'b1, 2'h0, 2'h1, `MSD_TRI_Z);
		failures = 0;
		num_checks = 0;
		cyc(6);
		rst_i <= 1'b0;
		t_dis;
		t_ind;
		t_latch;
		t_pins;
		stop_test;
	end
endmodule // tb
